/* rtl/pwgb_bridge.sv */
// ahb to apb bridge with peripheral write guard
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// R1: one guard store per bridge, bit per peripheral
// R2: debugger writes ignore protection
// R3: clear location write one unprotects
// R4: set location write one protects
// R5: both locations read the same bits
// R6: protected write dropped, error returned
// R7: clearing an unprotected bit errors
// R8: setting a protected bit errors
// R9: writing zero changes nothing
// R10: byte, halfword and word accesses supported
// R11: bits 1 to 6 guard system peripherals
// R12: runs whenever its clock runs; the code holds all its state while ce is low, except that sys_rst still resets it
// R13: ahb slave driving apb, waits and errors
// R14: apb setup and access merged
// R15: byte strobes apply to reads too
// R16: clock must run before transfers
// R17: reads never blocked; errors via ahb
module pwgb_bridge (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [3:0] hprot,
  input wire logic [3:0] hmaster,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [31:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  output logic [2:0] pprot,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic [31:0] write_protect_status
);
  // --------------------------------------------------
  // declarations
  // --------------------------------------------------
  pwgb_pkg::pwgb_state_e state_q;
  logic hreadyout_q, hresp_q, psel_q, pwrite_q;
  logic [31:0] hrdata_q, paddr_q, pwdata_q, addr_q, guard_bits, wmask, wones;
  logic [3:0] pstrb_q, lanes_q;
  logic [2:0] pprot_q, hprot_q;
  logic wr_q, dbg_q, take, is_guard, is_clr, is_set, guard_bad, guard_req, dbl_err, blocked;
  localparam int SLOT_W_L = pwgb_pkg::SLOT_W;
  logic [SLOT_W_L-1:0] slot;

  function automatic logic [3:0] lanes(input logic [2:0] sz, input logic [1:0] a);
    if (sz == pwgb_pkg::SIZE_BYTE) begin
      lanes = 4'h1 << a;
    end else if (sz == pwgb_pkg::SIZE_HALF) begin
      lanes = a[1] ? 4'hC : 4'h3;
    end else begin
      lanes = 4'hF;
    end
  endfunction

  // --------------------------------------------------
  // address phase decode
  // --------------------------------------------------
  // hreadyout is high only in idle or the error tail, so new work starts there
  assign take = hsel && htrans[1] && hready && hreadyout_q; // R13
  assign slot = addr_q[pwgb_pkg::SLOT_LSB +: SLOT_W_L];
  assign is_guard = (slot == pwgb_pkg::GUARD_SLOT);
  assign is_clr = (addr_q[9:2] == pwgb_pkg::CLR_IDX);
  assign is_set = (addr_q[9:2] == pwgb_pkg::SET_IDX);
  assign guard_bad = is_guard && !is_clr && !is_set;
  assign wmask = {{8{lanes_q[3]}}, {8{lanes_q[2]}}, {8{lanes_q[1]}}, {8{lanes_q[0]}}}; // R10
  assign wones = hwdata & wmask & pwgb_pkg::GUARD_MASK;
  assign guard_req = (state_q == pwgb_pkg::ST_DATA) && is_guard && wr_q && (is_clr || is_set);
  // reads pass unchecked; debugger writes bypass the guard
  assign blocked = !is_guard && wr_q && !dbg_q && guard_bits[slot]; // R2 R6 R17

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      addr_q <= 32'h00000000;
      wr_q <= 1'b0;
      dbg_q <= 1'b0;
      lanes_q <= 4'h0;
      hprot_q <= 3'h0;
    end else if (ce && take) begin // R12 R16
      addr_q <= haddr;
      wr_q <= hwrite;
      dbg_q <= (hmaster == pwgb_pkg::DEBUG_MASTER_ID);
      lanes_q <= lanes(hsize, haddr[1:0]); // R10
      hprot_q <= {!hprot[0], 1'b0, hprot[1]}; // R13
    end
  end

  // --------------------------------------------------
  // guard store
  // --------------------------------------------------
  pwgb_guard u_guard ( // R1 R11
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .req(guard_req),
    .set_sel(is_set),
    .wdata(wones),
    .dbl_err(dbl_err),
    .bits_q(guard_bits)
  );

  // --------------------------------------------------
  // transfer sequencer
  // --------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= pwgb_pkg::ST_IDLE;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else if (ce) begin
      unique case (state_q)
        pwgb_pkg::ST_IDLE: begin
          if (take) begin
            state_q <= pwgb_pkg::ST_DATA;
            hreadyout_q <= 1'b0;
          end
        end
        pwgb_pkg::ST_DATA: begin
          if ((is_guard && (guard_bad || (guard_req && dbl_err))) || blocked) begin
            state_q <= pwgb_pkg::ST_ERR1; // R6 R7 R8 R17
            hresp_q <= 1'b1;
          end else if (is_guard) begin
            state_q <= pwgb_pkg::ST_IDLE;
            hreadyout_q <= 1'b1;
          end else begin
            state_q <= pwgb_pkg::ST_APB;
          end
        end
        pwgb_pkg::ST_APB: begin
          if (pready) begin // R13
            if (pslverr) begin
              state_q <= pwgb_pkg::ST_ERR1;
              hresp_q <= 1'b1;
            end else begin
              state_q <= pwgb_pkg::ST_IDLE;
              hreadyout_q <= 1'b1;
            end
          end
        end
        pwgb_pkg::ST_ERR1: begin
          // two-cycle ahb error response
          state_q <= pwgb_pkg::ST_ERR2;
          hreadyout_q <= 1'b1;
        end
        pwgb_pkg::ST_ERR2: begin
          hresp_q <= 1'b0;
          if (take) begin
            state_q <= pwgb_pkg::ST_DATA;
            hreadyout_q <= 1'b0;
          end else begin
            state_q <= pwgb_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= pwgb_pkg::ST_IDLE;
          hreadyout_q <= 1'b1;
          hresp_q <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------
  // apb side, setup merged into the access phase, held until pready
  // --------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      psel_q <= 1'b0;
      pwrite_q <= 1'b0;
      paddr_q <= 32'h00000000;
      pwdata_q <= 32'h00000000;
      pstrb_q <= 4'h0;
      pprot_q <= 3'h0;
    end else if (ce) begin
      if (state_q == pwgb_pkg::ST_DATA && !is_guard && !blocked) begin
        psel_q <= 1'b1; // R14
        pwrite_q <= wr_q;
        paddr_q <= addr_q;
        pwdata_q <= hwdata;
        pstrb_q <= lanes_q; // R15
        pprot_q <= hprot_q;
      end else if (state_q == pwgb_pkg::ST_APB && pready) begin
        psel_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------
  // read data
  // --------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hrdata_q <= 32'h00000000;
    end else if (ce) begin
      if (state_q == pwgb_pkg::ST_DATA && is_guard && !wr_q) begin
        hrdata_q <= guard_bits; // R5
      end else if (state_q == pwgb_pkg::ST_APB && pready) begin
        hrdata_q <= prdata;
      end
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;
  assign paddr = paddr_q;
  assign psel = psel_q;
  assign penable = psel_q;
  assign pwrite = pwrite_q;
  assign pwdata = pwdata_q;
  assign pstrb = pstrb_q;
  assign pprot = pprot_q;
  assign write_protect_status = guard_bits;

  // --------------------------------------------------
  // checks
  // --------------------------------------------------
  AST_ERR_TAIL: assert property (@(posedge mclk) disable iff (sys_rst) // R6
    ce && state_q == pwgb_pkg::ST_ERR1 |=> hresp && hreadyout)
    else $error("error response tail wrong");
  AST_BLOCK_NO_APB: assert property (@(posedge mclk) disable iff (sys_rst) // R6
    ce && state_q == pwgb_pkg::ST_DATA && blocked |=> !psel ##1 hresp && hreadyout)
    else $error("protected write reached apb");
  AST_DEBUG_BYPASS: assert property (@(posedge mclk) disable iff (sys_rst) // R2
    ce && state_q == pwgb_pkg::ST_DATA && !is_guard && wr_q && dbg_q |=> psel && pwrite)
    else $error("debugger write not forwarded");
  AST_MERGED: assert property (@(posedge mclk) disable iff (sys_rst) // R14
    ce && state_q == pwgb_pkg::ST_DATA && !is_guard && !blocked |=> psel && penable && !$past(psel))
    else $error("apb setup cycle seen");
  AST_SET: assert property (@(posedge mclk) disable iff (sys_rst) // R4
    ce && guard_req && is_set && !dbl_err |=> guard_bits == ($past(guard_bits) | $past(wones)))
    else $error("set location update wrong");
  AST_CLR: assert property (@(posedge mclk) disable iff (sys_rst) // R3
    ce && guard_req && is_clr && !dbl_err |=> guard_bits == ($past(guard_bits) & ~$past(wones)))
    else $error("clear location update wrong");
  AST_DBL_SET: assert property (@(posedge mclk) disable iff (sys_rst) // R8
    ce && guard_req && is_set && |(wones & guard_bits) |=> $stable(guard_bits) && hresp)
    else $error("double protect not refused");
  AST_DBL_CLR: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    ce && guard_req && is_clr && |(wones & ~guard_bits) |=> $stable(guard_bits) && hresp)
    else $error("double unprotect not refused");
  AST_READ_FREE: assert property (@(posedge mclk) disable iff (sys_rst) // R17
    ce && state_q == pwgb_pkg::ST_DATA && !is_guard && !wr_q |=> psel && !pwrite)
    else $error("read was blocked");
  AST_STROBE: assert property (@(posedge mclk) disable iff (sys_rst) // R15
    psel |-> pstrb != 4'h0)
    else $error("apb strobes empty");
  AST_RESERVED: assert property (@(posedge mclk) disable iff (sys_rst) // R11
    (guard_bits & ~pwgb_pkg::GUARD_MASK) == 32'h00000000)
    else $error("reserved guard bit set");
  COV_BLOCKED: cover property (@(posedge mclk) ce && state_q == pwgb_pkg::ST_DATA && blocked);
  COV_DBL: cover property (@(posedge mclk) ce && guard_req && dbl_err);
  COV_APB_WAIT: cover property (@(posedge mclk) psel && !pready ##1 psel && pready);
endmodule
`default_nettype wire

/* rtl/pwgb_pkg.sv */
// constants and types shared by the write guard bridge
package pwgb_pkg;
  // --------------------------------------------------
  // address map inside the bridge window
  // --------------------------------------------------
  localparam int SLOT_LSB = 10;
  localparam int SLOT_W = 5;
  localparam logic [SLOT_W-1:0] GUARD_SLOT = 5'h00;
  localparam logic [7:0] CLR_IDX = 8'h00;
  localparam logic [7:0] SET_IDX = 8'h01;
  // --------------------------------------------------
  // guard bit layout and reset value
  // --------------------------------------------------
  localparam int POWER_MANAGER_GUARD_BIT = 1;
  localparam int SYSTEM_CONTROL_GUARD_BIT = 2;
  localparam int GENERIC_CLOCK_GUARD_BIT = 3;
  localparam int WATCHDOG_GUARD_BIT = 4;
  localparam int REAL_TIME_COUNTER_GUARD_BIT = 5;
  localparam int EXT_INTERRUPT_GUARD_BIT = 6;
  localparam logic [31:0] GUARD_MASK = 32'h0000007E;
  localparam logic [31:0] GUARD_RESET = 32'h00000000;
  // --------------------------------------------------
  // bus encodings
  // --------------------------------------------------
  localparam logic [3:0] DEBUG_MASTER_ID = 4'h1;
  localparam logic [2:0] SIZE_BYTE = 3'h0;
  localparam logic [2:0] SIZE_HALF = 3'h1;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DATA = 5'h02,
    ST_APB = 5'h04,
    ST_ERR1 = 5'h08,
    ST_ERR2 = 5'h10
  } pwgb_state_e;
endpackage

/* rtl/pwgb_guard.sv */
// protection bit store with set and clear locations
`timescale 1ns/100ps
`default_nettype none
module pwgb_guard (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic req,
  input wire logic set_sel,
  input wire logic [31:0] wdata,
  output logic dbl_err,
  output logic [31:0] bits_q
);
  logic [31:0] ones;

  // reserved bits never take part, so they cannot raise errors
  assign ones = wdata & pwgb_pkg::GUARD_MASK;

  always_comb begin
    if (set_sel) begin
      dbl_err = |(ones & bits_q); // R8
    end else begin
      dbl_err = |(ones & ~bits_q); // R7
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bits_q <= pwgb_pkg::GUARD_RESET;
    end else if (ce && req && !dbl_err) begin
      if (set_sel) begin
        bits_q <= bits_q | ones; // R4 R9
      end else begin
        bits_q <= bits_q & ~ones; // R3 R9
      end
    end
  end
endmodule
`default_nettype wire

/* dv/pwgb_apb_model.sv */
// apb completer standing behind the bridge
`timescale 1ns/100ps
`default_nettype none
module pwgb_apb_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [1:0] waits,
  input wire logic err,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] mem_q
);
  // ----------------------------------------
  // wait counter and one data register
  // ----------------------------------------
  logic [1:0] cnt_q;
  assign pready = psel && cnt_q == waits;
  assign pslverr = pready && err;
  // inverted when idle so a stale value never passes
  assign prdata = pready ? mem_q : ~mem_q;
  always_ff @(posedge mclk) begin
    if (sys_rst || !psel || pready) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mem_q <= 32'h0;
    end else if (pready && pwrite && !err) begin
      mem_q <= pwdata;
    end
  end
endmodule
`default_nettype wire

/* dv/peripheral_write_guard_bridge_bench.sv */
// self-checking bench for the write guard bridge
`timescale 1ns/100ps
`default_nettype none
module peripheral_write_guard_bridge_bench;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic mclk, sys_rst, ce, hsel, hwrite, hreadyout, hresp, psel, penable, pwrite, pready, pslverr, err_cmd;
  logic [31:0] haddr, hwdata, hrdata, paddr, pwdata, prdata, status, mem, rd, seen_addr;
  logic [1:0] htrans, waits;
  logic [2:0] hsize, pprot, seen_prot;
  logic [3:0] hprot, hmaster, pstrb, seen_strb;
  int num_errors, total_checks, cyc, npsel;
  pwgb_bridge u_pwgb_bridge (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hprot(hprot), .hmaster(hmaster), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .write_protect_status(status));
  pwgb_apb_model u_pwgb_apb_model (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .pwrite(pwrite),
    .pwdata(pwdata), .waits(waits), .err(err_cmd), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_q(mem));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic final_report;
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  // one ahb transfer; waits bounded, then checks the response
  task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] s, input logic [3:0] m,
    input logic [31:0] d, input logic ee);
    int n;
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= s;
    hmaster <= m;
    @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    rd = hrdata;
    // a hung transfer must count, not slip through on a quiet hresp
    chk({31'h0, hreadyout}, 32'h1);
    chk({31'h0, hresp}, {31'h0, ee});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    xfer(32'h0, 1'b0, 3'h2, 4'h0, 32'h0, 1'b0);
    chk(rd, pwgb_pkg::GUARD_RESET);
    xfer(32'h4, 1'b0, 3'h2, 4'h0, 32'h0, 1'b0);
    chk(rd, pwgb_pkg::GUARD_RESET);
  endtask
  task automatic t_set;
    xfer(32'h4, 1'b1, 3'h2, 4'h0, 32'hFFFFFF94, 1'b0);
    chk(status, 32'h00000014);
    xfer(32'h0, 1'b0, 3'h2, 4'h0, 32'h0, 1'b0);
    chk(rd, 32'h00000014);
    xfer(32'h0, 1'b1, 3'h2, 4'h0, 32'h0, 1'b0);
    chk(status, 32'h00000014);
    xfer(32'h4, 1'b1, 3'h2, 4'h0, 32'h00000012, 1'b1);
    chk(status, 32'h00000014);
  endtask
  task automatic t_guard;
    int p;
    p = npsel;
    xfer(32'h1000, 1'b1, 3'h2, 4'h0, 32'hA5A5A5A5, 1'b1);
    chk(npsel - p, 32'h0);
    chk(mem, 32'h0);
    waits <= 2'h3;
    xfer(32'h1000, 1'b1, 3'h2, 4'h1, 32'hA5A5A5A5, 1'b0);
    chk(mem, 32'hA5A5A5A5);
    chk({29'h0, seen_prot}, 32'h1);
    waits <= 2'h0;
    xfer(32'h1002, 1'b0, pwgb_pkg::SIZE_HALF, 4'h0, 32'h0, 1'b0);
    chk(rd, 32'hA5A5A5A5);
    chk({28'h0, seen_strb}, 32'hC);
    chk(seen_addr, 32'h00001002);
  endtask
  task automatic t_clear;
    xfer(32'h0, 1'b1, 3'h2, 4'h0, 32'h00000004, 1'b0);
    chk(status, 32'h00000010);
    xfer(32'h0, 1'b1, 3'h2, 4'h0, 32'h00000004, 1'b1);
    xfer(32'h1000, 1'b1, 3'h2, 4'h0, 32'h0, 1'b1);
  endtask
  task automatic t_bytes;
    xfer(32'h4, 1'b1, pwgb_pkg::SIZE_BYTE, 4'h0, 32'h00000002, 1'b0);
    chk(status, 32'h00000012);
    xfer(32'h7, 1'b1, pwgb_pkg::SIZE_BYTE, 4'h0, 32'h00000040, 1'b0);
    chk(status, 32'h00000012);
  endtask
  task automatic t_faults;
    xfer(32'h8, 1'b0, 3'h2, 4'h0, 32'h0, 1'b1);
    err_cmd <= 1'b1;
    // slot 2 is unprotected, so the error can only come from the completer
    xfer(32'h800, 1'b1, 3'h2, 4'h0, 32'h1, 1'b1);
    chk(mem, 32'hA5A5A5A5);
    err_cmd <= 1'b0;
  endtask
  task automatic t_freeze;
    @(posedge mclk);
    ce <= 1'b0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= 32'h4;
    hwrite <= 1'b1;
    hwdata <= 32'h00000004;
    repeat (3) @(posedge mclk);
    #1;
    chk(status, 32'h00000012);
    chk({31'h0, hreadyout}, 32'h1);
    @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    ce <= 1'b1;
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk(status, pwgb_pkg::GUARD_RESET);
  endtask
  // ----------------------------------------
  // clock, monitor, timeout and main flow
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (psel) begin
      npsel++;
      seen_strb <= pstrb;
      seen_prot <= pprot;
      seen_addr <= paddr;
    end
    if (cyc == 3000) begin
      num_errors++;
      final_report;
    end
  end
  initial begin
    {sys_rst, ce, hsel, hwrite, err_cmd} = 5'b11000;
    {haddr, hwdata, htrans, waits, hsize, hmaster} = '0;
    hprot = 4'h3;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset;
    t_set;
    t_guard;
    t_clear;
    t_bytes;
    t_faults;
    t_freeze;
    final_report;
  end
endmodule
`default_nettype wire
